// ### verilog/bwdt_pkg.sv
// Package of constants for the board watchdog timer
package bwdt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REFRESH_PORT_ADDR = 8'h93;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int TICK_HZ = 1000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int TIMEOUT_SHORT_S = 2;
    localparam int TIMEOUT_LONG_S = 8;
    localparam int TIMEOUT_SHORT_TICKS = TIMEOUT_SHORT_S * TICK_HZ;
    localparam int TIMEOUT_LONG_TICKS = TIMEOUT_LONG_S * TICK_HZ;
    localparam int RESET_PULSE_CYCLES = 64;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BWDT_DISARMED,
        BWDT_ARMED,
        BWDT_FIRING
    } bwdt_state_t;
endpackage

// ### verilog/bwdt_tick_div.sv
// Slow reference tick divider for the board watchdog
`timescale 1ns/1ps
module bwdt_tick_div #(
    parameter int DIV = 20000
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_restart,
    output logic o_tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } bwdt_div_t;

    bwdt_div_t s_q;
    bwdt_div_t s_d;

    // Count down to one tick per DIV clocks, restart aligns phase
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (i_restart || s_q.cnt == 16'h0000) begin
            s_d.cnt = 16'(DIV - 1);
            s_d.tick = ~i_restart;
        end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;
endmodule

// ### verilog/bwdt_top.sv
// Board watchdog timer: armed and refreshed by writes to one I/O port
// Contract
// - Timeout is 2 s or 8 s, chosen by the timeout select link.
// - Reset leaves the watchdog disarmed; no timeout before arming.
// - Any write to port 93h arms the watchdog and starts timing.
// - Armed and not refreshed within the timeout asserts board reset.
// - Once armed, nothing but a board reset disarms it.
// - Enable link removed means no new watchdog reset is started; a pulse under way runs out.
`timescale 1ns/1ps
module bwdt_top
    import bwdt_pkg::*;
#(
    parameter int TICK_DIV_P = TICK_DIV // Clocks per tick; shortened only for simulation
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_IO_WR,
    input wire logic [7:0] I_IO_ADDR,
    input wire logic [7:0] I_IO_DATA,
    input wire logic I_TIMEOUT_SELECT_LINK,
    input wire logic I_WATCHDOG_ENABLE_LINK,
    output logic O_BOARD_RESET,
    output logic O_ARMED
);
    import bwdt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bwdt_state_t st;
        logic [13:0] ticks;
        logic [7:0] pulse;
        logic rst_out;
    } bwdt_regs_t;

    bwdt_regs_t r_q;
    bwdt_regs_t r_d;
    logic refresh;
    logic tick;
    logic [13:0] limit;

    // Data value is ignored; only the address matters
    assign refresh = I_IO_WR && (I_IO_ADDR == REFRESH_PORT_ADDR);

    // Timeout selected by the link
    assign limit = I_TIMEOUT_SELECT_LINK ? 14'(TIMEOUT_LONG_TICKS)
                                         : 14'(TIMEOUT_SHORT_TICKS);

    // ------------------------------------------------------------
    // Usage notes
    // ------------------------------------------------------------
    // Keep TICK_DIV_P at its default in silicon
    // Timeout counts whole ticks, phase restarted by every refresh
    // Enable link looked at only on the expiry tick
    // After a pulse the timer stays armed and times again
    // Board reset loops back to I_RST outside this block

    // ------------------------------------------------------------
    // Tick generator
    // ------------------------------------------------------------
    bwdt_tick_div #(
        .DIV(TICK_DIV_P)
    ) u_div (
        .I_CLK(I_CLK),
        .I_RST(I_RST),
        .i_restart(refresh),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // Watchdog sequencing
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.rst_out = 1'b0;
        case (r_q.st)
            BWDT_DISARMED: begin
                if (refresh) begin
                    r_d.st = BWDT_ARMED;
                    r_d.ticks = 14'h0000;
                end
            end
            BWDT_ARMED: begin
                if (refresh) begin
                    r_d.ticks = 14'h0000;
                end else if (tick) begin
                    if (r_q.ticks + 14'h0001 >= limit) begin
                        if (I_WATCHDOG_ENABLE_LINK) begin
                            r_d.st = BWDT_FIRING;
                            r_d.pulse = 8'(RESET_PULSE_CYCLES - 1);
                            r_d.rst_out = 1'b1;
                        end
                        r_d.ticks = 14'h0000;
                    end else begin
                        r_d.ticks = r_q.ticks + 14'h0001;
                    end
                end
            end
            BWDT_FIRING: begin
                // Fixed-length pulse, stays armed until board reset
                if (r_q.pulse != 8'h00) begin
                    r_d.pulse = r_q.pulse - 8'h01;
                    r_d.rst_out = 1'b1;
                end else begin
                    r_d.st = BWDT_ARMED;
                    r_d.ticks = 14'h0000;
                end
            end
            default: begin
                r_d.st = BWDT_DISARMED;
            end
        endcase
    end

    // State register; reset disarms
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign O_BOARD_RESET = r_q.rst_out;
    assign O_ARMED = (r_q.st != BWDT_DISARMED);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_NO_RESET_DISARMED: assert property (@(posedge I_CLK) disable iff (I_RST)
        (r_q.st == BWDT_DISARMED) |-> !O_BOARD_RESET)
        else $error("reset pulse while disarmed");

    AST_WRITE_ARMS: assert property (@(posedge I_CLK) disable iff (I_RST)
        refresh |=> O_ARMED)
        else $error("write did not arm watchdog");

    AST_STAYS_ARMED: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_ARMED |=> O_ARMED)
        else $error("watchdog disarmed without reset");

    AST_LINK_OFF_QUIET: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!I_WATCHDOG_ENABLE_LINK && !O_BOARD_RESET) |=> !$rose(O_BOARD_RESET))
        else $error("reset with enable link removed");

    AST_REFRESH_CLEARS: assert property (@(posedge I_CLK) disable iff (I_RST)
        (refresh && r_q.st == BWDT_ARMED) |=> (r_q.ticks == 14'h0000))
        else $error("refresh did not restart count");

    AST_PULSE_LEN: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(O_BOARD_RESET) |-> O_BOARD_RESET [*8])
        else $error("reset pulse too short");

    AST_FIRE_AT_LIMIT: assert property (@(posedge I_CLK) disable iff (I_RST)
        (r_q.st == BWDT_ARMED && tick && !refresh && I_WATCHDOG_ENABLE_LINK
         && r_q.ticks + 14'h0001 >= limit) |=> O_BOARD_RESET)
        else $error("no reset at timeout");

    AST_NO_EARLY_FIRE: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(O_BOARD_RESET) |-> $past(r_q.ticks) + 14'h0001 >= $past(limit))
        else $error("reset before selected timeout");

    // ------------------------------------------------------------
    // Assertions on counting and pulse shape
    // ------------------------------------------------------------
    // Count never passes the longest timeout
    AST_COUNT_BOUNDED: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_ARMED
        |-> (r_q.ticks < 14'(TIMEOUT_LONG_TICKS)))
        else $error("tick count beyond longest timeout");

    // Disarmed means no time is being counted
    AST_DISARMED_IDLE: assert property (@(posedge I_CLK) disable iff (I_RST)
        !O_ARMED
        |-> (r_q.ticks == 14'h0000))
        else $error("counting while disarmed");

    // Nothing but a write arms the watchdog
    AST_ONLY_WRITE_ARMS: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!O_ARMED && !refresh)
        |=> !O_ARMED)
        else $error("armed without a write");

    // Arming write starts timing from zero
    AST_ARM_FROM_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
        (refresh && !O_ARMED)
        |=> (r_q.ticks == 14'h0000))
        else $error("arming did not start from zero");

    // Link removed blocks the firing state
    AST_LINK_OFF_NO_FIRING: assert property (@(posedge I_CLK) disable iff (I_RST)
        (r_q.st == BWDT_ARMED && !I_WATCHDOG_ENABLE_LINK)
        |=> (r_q.st != BWDT_FIRING))
        else $error("firing with enable link removed");

    // Count moves only on a divided tick or a refresh
    AST_TICK_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
        (r_q.st == BWDT_ARMED && !refresh && !tick)
        |=> $stable(r_q.ticks))
        else $error("count moved without a tick");

    // Firing only follows a tick
    AST_FIRE_NEEDS_TICK: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(O_BOARD_RESET)
        |-> $past(tick))
        else $error("reset pulse without a tick");

    // Pulse starts with the full length loaded
    AST_PULSE_START: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(O_BOARD_RESET)
        |-> (r_q.pulse == 8'(RESET_PULSE_CYCLES - 1)))
        else $error("reset pulse length not loaded");

    // Pulse ends once its count is spent
    AST_PULSE_ENDS: assert property (@(posedge I_CLK) disable iff (I_RST)
        (r_q.st == BWDT_FIRING && r_q.pulse == 8'h00)
        |=> !O_BOARD_RESET)
        else $error("reset pulse too long");

    // Reset output only while firing
    AST_PULSE_ONLY_FIRING: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_BOARD_RESET
        |-> (r_q.st == BWDT_FIRING))
        else $error("reset output outside firing");
endmodule

// ### verif/testbench.sv
// Self-checking testbench for the board watchdog timer
`timescale 1ns/1ps
module testbench;
    import bwdt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] data = 8'h00;
    logic tsel = 1'b0;
    logic en = 1'b1;
    logic brst, armed;
    localparam int DIV_SIM = 4;
    localparam int SHORT_CYC = TIMEOUT_SHORT_TICKS * DIV_SIM;
    localparam int LONG_CYC = TIMEOUT_LONG_TICKS * DIV_SIM;
    localparam int CYCLE_LIMIT = 90000;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    // ----------------------------------------
    // Clock and design with a short tick
    // ----------------------------------------
    always #25 clk = ~clk;
    bwdt_top #(.TICK_DIV_P(DIV_SIM)) bwdt_top_inst (.I_CLK(clk), .I_RST(rst), .I_IO_WR(wr),
        .I_IO_ADDR(addr), .I_IO_DATA(data), .I_TIMEOUT_SELECT_LINK(tsel),
        .I_WATCHDOG_ENABLE_LINK(en), .O_BOARD_RESET(brst), .O_ARMED(armed));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_cnt(input string name, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic io_write(input logic [7:0] a);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        data = 8'h5a;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic print_verdict();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_other_addr();
        io_write(8'h92);
        io_write(8'h94);
        check_bit("armed after other ports", 1'b0, armed);
    endtask
    task automatic t_arm_refresh();
        io_write(REFRESH_PORT_ADDR);
        check_bit("armed after write", 1'b1, armed);
        tsel = 1'b1;
        io_write(REFRESH_PORT_ADDR);
        repeat (100) @(negedge clk);
        check_bit("no early board reset", 1'b0, brst);
        check_bit("still armed", 1'b1, armed);
    endtask
    task automatic t_reset_disarms();
        do_reset();
        @(negedge clk);
        check_bit("armed after reset", 1'b0, armed);
        check_bit("board reset after reset", 1'b0, brst);
    endtask
    // Cycles from the end of a write until the board reset shows
    task automatic wait_board_reset(input int max, output int n);
        n = 0;
        while (brst !== 1'b1 && n < max) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Cycles the board reset stands
    task automatic pulse_width(output int n);
        n = 0;
        while (brst === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_short_timeout();
        int n;
        tsel = 1'b0;
        en = 1'b1;
        do_reset();
        io_write(REFRESH_PORT_ADDR);
        wait_board_reset(SHORT_CYC + 10, n);
        check_cnt("short timeout cycles", SHORT_CYC, n);
        check_bit("board reset at short timeout", 1'b1, brst);
        pulse_width(n);
        check_cnt("board reset pulse cycles", RESET_PULSE_CYCLES, n);
        check_bit("armed after pulse", 1'b1, armed);
    endtask
    task automatic t_refresh_restart();
        int n;
        tsel = 1'b0;
        en = 1'b1;
        do_reset();
        io_write(REFRESH_PORT_ADDR);
        repeat (SHORT_CYC - 40) @(negedge clk);
        check_bit("no reset before refresh", 1'b0, brst);
        io_write(REFRESH_PORT_ADDR);
        wait_board_reset(SHORT_CYC + 10, n);
        check_cnt("timeout after refresh", SHORT_CYC, n);
    endtask
    task automatic t_long_timeout();
        int n;
        tsel = 1'b1;
        en = 1'b1;
        do_reset();
        io_write(REFRESH_PORT_ADDR);
        wait_board_reset(LONG_CYC + 10, n);
        check_cnt("long timeout cycles", LONG_CYC, n);
        check_bit("board reset at long timeout", 1'b1, brst);
    endtask
    task automatic t_link_removed();
        int n;
        tsel = 1'b0;
        en = 1'b0;
        do_reset();
        io_write(REFRESH_PORT_ADDR);
        wait_board_reset(SHORT_CYC + 100, n);
        check_cnt("quiet cycles with link removed", SHORT_CYC + 100, n);
        check_bit("board reset with link removed", 1'b0, brst);
        check_bit("armed with link removed", 1'b1, armed);
        en = 1'b1;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == CYCLE_LIMIT) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        do_reset();
        t_reset_disarms();
        t_other_addr();
        t_arm_refresh();
        t_reset_disarms();
        t_short_timeout();
        t_refresh_restart();
        t_long_timeout();
        t_link_removed();
        print_verdict();
    end
endmodule
